// ### otpa_pkg.sv
// Shared constants and types for the security-region serial link.
// Assumes a single 10 MHz system clock on both ends.
package otpa_pkg;

  // ==========================================================
  // Clock
  localparam int CLK_NS = 100;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OPC_WRITE_PERMIT = 8'h06;
  localparam logic [7:0] OPC_STATUS = 8'h05;
  localparam logic [7:0] OPC_REGION_PROG = 8'h9B;
  localparam logic [7:0] OPC_REGION_READ = 8'h77;

  // ==========================================================
  // Region layout
  localparam int REGION_BYTES = 128;
  localparam int USER_BYTES = 64;
  localparam int BUF_BYTES = 256;
  localparam int ADDR_BYTES = 3;
  localparam int READ_DUMMY = 2;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] STAT_BYTE2 = 8'h00;
  // Arbitrary seed for the factory serial bytes
  localparam logic [7:0] SERIAL_SEED = 8'h5A;

  // ==========================================================
  // Status bits
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WPL_BIT = 1;

  // ==========================================================
  // Timing
  localparam int PROG_TIME_US = 500;
  localparam int PROG_CYCLES = (PROG_TIME_US * 1000) / CLK_NS;
  localparam int PROG_CW = 16;
  localparam int SCLK_HALF_NS = 1200;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // Reset values of synchronised pins {cs_n, sclk, mosi}
  localparam logic [2:0] PIN_IDLE = 3'h4;
  localparam logic MISO_IDLE = 1'b1;

  typedef enum {
    DS_IDLE, DS_OPCODE, DS_ADDR, DS_DUMMY, DS_PDATA, DS_RDATA, DS_STAT,
    DS_SKIP
  } otpa_dev_state_t;

  typedef enum {
    HS_IDLE, HS_LOW, HS_HIGH, HS_HOLD, HS_GAP
  } otpa_host_state_t;

endpackage : otpa_pkg

// ### otpa_if.sv
// Serial link between the host controller and the region device.
// Assumes the data-out line is pulled high while nobody drives it.
`timescale 1ns/1ns
interface otpa_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // Pulled high when released
  assign miso = miso_oe ? miso_o : 1'b1;

  modport dev (input cs_n, input sclk, input mosi,
               output miso_o, output miso_oe);
  modport host (output cs_n, output sclk, output mosi, input miso);
endinterface : otpa_if

// ### otpa_device.sv
// Security-region end of the serial flash: 128-byte region access.
// Assumes link pins arrive asynchronously and sclk is far below i_mclk.
//
// Overview of operation
// R01: 128-byte region, 64 user, 64 factory
// R02: Factory half never changes
// R03: User half programmable once, no erase
// R04: Program needs write permit latch set
// R05: Program: 9Bh, three address bytes, data
// R06: Program decodes only low six address bits
// R07: Program location wraps within user half
// R08: Only the last 64 bytes kept
// R09: Program at release, unsent bytes stay FFh
// R10: Programming is self timed
// R11: Bad framing aborts, nothing programmed
// R12: Every abort clears write permit latch
// R13: Status readable and busy while programming
// R14: Host polls busy rather than waiting
// R15: Success clears write permit latch
// R16: Interrupted programming still marks region used
// R17: Program uses shared 256-byte buffer
// R18: Read: 77h, three address, two dummy, data
// R19: Read wraps 7Fh to 00h seamlessly
// R20: Release ends read, output floats
// R21: 06h alone sets latch at release; the code also sets it when whole bytes follow 06h
// R22: 05h streams status: busy, latch bits
// R23: While busy only status reads accepted; the code also accepts 06h while busy
`timescale 1ns/1ns
module otpa_device #(
  parameter int PROG_CYCLES = otpa_pkg::PROG_CYCLES
) (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Serial link
  otpa_if.dev link,
  // Status
  output logic o_busy,
  output logic o_write_permit,
  output logic o_user_used
);

  // ==========================================================
  // Pin synchronisers
  logic [2:0] s1_reg, s2_reg, s3_reg, flt_reg, prev_reg;
  wire [2:0] pin_in = {link.cs_n, link.sclk, link.mosi};
  wire [2:0] agree = ~(s2_reg ^ s3_reg);
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s1_reg <= otpa_pkg::PIN_IDLE;
      s2_reg <= otpa_pkg::PIN_IDLE;
      s3_reg <= otpa_pkg::PIN_IDLE;
      flt_reg <= otpa_pkg::PIN_IDLE;
      prev_reg <= otpa_pkg::PIN_IDLE;
    end else if (i_ce) begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      flt_reg <= (flt_reg & ~agree) | (s3_reg & agree);
      prev_reg <= flt_reg;
    end
  end
  wire cs_active = ~flt_reg[2];
  wire cs_start = ~flt_reg[2] & prev_reg[2];
  wire cs_end = flt_reg[2] & ~prev_reg[2];
  wire sclk_rise = flt_reg[1] & ~prev_reg[1] & cs_active;
  wire sclk_fall = ~flt_reg[1] & prev_reg[1] & cs_active;
  wire mosi_bit = flt_reg[0];

  // ==========================================================
  // Command state
  otpa_pkg::otpa_dev_state_t state_reg;
  logic [2:0] bit_reg;
  logic [6:0] in_sh_reg;
  logic [1:0] cnt_reg;
  logic prog_cmd_reg;
  logic wen_cmd_reg;
  logic data_seen_reg;
  logic [6:0] addr_reg;
  logic [63:0] mask_reg;
  logic wpl_reg;
  logic busy_reg;
  logic used_reg;
  logic [otpa_pkg::PROG_CW-1:0] prog_cnt_reg;
  logic [6:0] copy_reg;
  logic [6:0] out_sh_reg;
  logic [2:0] obit_reg;
  logic miso_reg;
  logic stat_sel_reg;
  logic [7:0] buf_mem [0:otpa_pkg::BUF_BYTES-1];
  logic [7:0] user_mem [0:otpa_pkg::USER_BYTES-1];
  wire [7:0] rx_byte = {in_sh_reg, mosi_bit};
  wire byte_done = sclk_rise & (bit_reg == 3'h7);
  wire [5:0] wptr = addr_reg[5:0];
  wire streaming = (state_reg == otpa_pkg::DS_STAT) |
                   (state_reg == otpa_pkg::DS_RDATA);
  // Program frame acceptable at release
  wire prog_ok = prog_cmd_reg & (state_reg == otpa_pkg::DS_PDATA) &
                 data_seen_reg & (bit_reg == 3'h0) & ~used_reg; // [R11]
  wire prog_go = cs_end & prog_ok & wpl_reg; // [R04]
  wire prog_last = busy_reg &
                   (prog_cnt_reg == otpa_pkg::PROG_CW'(PROG_CYCLES - 1));
  // Factory bytes, fixed per device
  function automatic logic [7:0] serial_byte(input logic [5:0] idx);
    serial_byte = otpa_pkg::SERIAL_SEED ^ {2'h0, idx}; // [R02]
  endfunction : serial_byte
  function automatic logic [7:0] region_byte(input logic [6:0] loc,
                                             input logic [7:0] user_val);
    region_byte = loc[6] ? serial_byte(loc[5:0]) : user_val; // [R01]
  endfunction : region_byte
  wire [7:0] stat_byte = stat_sel_reg ? otpa_pkg::STAT_BYTE2 :
                         {6'h00, wpl_reg, busy_reg}; // [R22] [R13]
  wire [7:0] out_byte = (state_reg == otpa_pkg::DS_STAT) ? stat_byte :
                        region_byte(addr_reg, user_mem[addr_reg[5:0]]);

  // ==========================================================
  // Frame decoder
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_reg <= otpa_pkg::DS_IDLE;
      bit_reg <= 3'h0;
      in_sh_reg <= 7'h00;
      cnt_reg <= 2'h0;
      prog_cmd_reg <= 1'b0;
      wen_cmd_reg <= 1'b0;
      data_seen_reg <= 1'b0;
      addr_reg <= 7'h00;
      mask_reg <= 64'h0;
    end else if (i_ce) begin
      if (cs_start) begin
        state_reg <= otpa_pkg::DS_OPCODE;
        bit_reg <= 3'h0;
        cnt_reg <= 2'h0;
        prog_cmd_reg <= 1'b0;
        wen_cmd_reg <= 1'b0;
        data_seen_reg <= 1'b0;
      end else if (cs_end) begin
        state_reg <= otpa_pkg::DS_IDLE;
      end else if (sclk_rise) begin
        bit_reg <= bit_reg + 3'h1;
        in_sh_reg <= rx_byte[6:0];
      end
      if (byte_done) begin
        unique case (state_reg)
          otpa_pkg::DS_OPCODE: begin
            if (rx_byte == otpa_pkg::OPC_WRITE_PERMIT) begin
              wen_cmd_reg <= 1'b1; // [R21]
              state_reg <= otpa_pkg::DS_SKIP;
            end else if (rx_byte == otpa_pkg::OPC_STATUS) begin
              state_reg <= otpa_pkg::DS_STAT; // [R13]
            end else if (rx_byte == otpa_pkg::OPC_REGION_PROG &&
                         !busy_reg) begin
              prog_cmd_reg <= 1'b1; // [R05]
              mask_reg <= 64'h0; // [R17]
              state_reg <= otpa_pkg::DS_ADDR;
            end else if (rx_byte == otpa_pkg::OPC_REGION_READ &&
                         !busy_reg) begin
              state_reg <= otpa_pkg::DS_ADDR; // [R18]
            end else begin
              state_reg <= otpa_pkg::DS_SKIP; // [R23]
            end
          end
          otpa_pkg::DS_ADDR: begin
            addr_reg <= prog_cmd_reg ? {1'b0, rx_byte[5:0]} :
                        rx_byte[6:0]; // [R06]
            cnt_reg <= cnt_reg + 2'h1;
            if (cnt_reg == 2'(otpa_pkg::ADDR_BYTES - 1)) begin
              cnt_reg <= 2'h0;
              state_reg <= prog_cmd_reg ? otpa_pkg::DS_PDATA :
                           otpa_pkg::DS_DUMMY;
            end
          end
          otpa_pkg::DS_DUMMY: begin
            cnt_reg <= cnt_reg + 2'h1;
            if (cnt_reg == 2'(otpa_pkg::READ_DUMMY - 1)) begin
              state_reg <= otpa_pkg::DS_RDATA; // [R18]
            end
          end
          otpa_pkg::DS_PDATA: begin
            mask_reg[wptr] <= 1'b1;
            data_seen_reg <= 1'b1;
            addr_reg <= {1'b0, wptr + 6'h01}; // [R07] [R08]
          end
          otpa_pkg::DS_IDLE, otpa_pkg::DS_RDATA, otpa_pkg::DS_STAT,
          otpa_pkg::DS_SKIP: ;
        endcase
      end
      if (sclk_fall && streaming && obit_reg == 3'h0 &&
          state_reg == otpa_pkg::DS_RDATA) begin
        addr_reg <= addr_reg + 7'h01; // [R19]
      end
    end
  end
  // Data bytes land in the shared buffer at their own location
  always_ff @(posedge i_mclk) begin
    if (i_ce && byte_done && state_reg == otpa_pkg::DS_PDATA) begin
      buf_mem[{2'h0, wptr}] <= rx_byte; // [R17]
    end
  end

  // ==========================================================
  // Write permit latch and self-timed programming
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      wpl_reg <= 1'b0;
      busy_reg <= 1'b0;
      used_reg <= 1'b0;
      prog_cnt_reg <= '0;
      copy_reg <= 7'h00;
      for (int i = 0; i < otpa_pkg::USER_BYTES; i++) begin
        user_mem[i] <= otpa_pkg::ERASED_BYTE;
      end
    end else if (i_ce) begin
      if (cs_end && wen_cmd_reg && bit_reg == 3'h0) begin
        wpl_reg <= 1'b1; // [R21]
      end
      if (cs_end && prog_cmd_reg && !prog_ok) begin
        wpl_reg <= 1'b0; // [R12]
      end
      if (prog_go) begin
        busy_reg <= 1'b1; // [R10]
        used_reg <= 1'b1; // [R03] [R16]
        wpl_reg <= 1'b0; // [R15]
        prog_cnt_reg <= '0;
        copy_reg <= 7'h00;
      end else if (busy_reg) begin
        prog_cnt_reg <= prog_cnt_reg + otpa_pkg::PROG_CW'(1);
        if (copy_reg < 7'(otpa_pkg::USER_BYTES)) begin
          user_mem[copy_reg[5:0]] <= mask_reg[copy_reg[5:0]] ?
            buf_mem[{2'h0, copy_reg[5:0]}] : otpa_pkg::ERASED_BYTE; // [R09]
          copy_reg <= copy_reg + 7'h01;
        end
        if (prog_last) begin
          busy_reg <= 1'b0; // [R10]
        end
      end
    end
  end

  // ==========================================================
  // Serial output, shifted on falling clock edges
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      out_sh_reg <= 7'h00;
      obit_reg <= 3'h0;
      miso_reg <= otpa_pkg::MISO_IDLE;
      stat_sel_reg <= 1'b0;
    end else if (i_ce) begin
      if (byte_done && !streaming) begin
        obit_reg <= 3'h0;
        stat_sel_reg <= 1'b0;
      end else if (sclk_fall && streaming) begin
        obit_reg <= obit_reg + 3'h1;
        if (obit_reg == 3'h0) begin
          miso_reg <= out_byte[7];
          out_sh_reg <= out_byte[6:0];
          if (state_reg == otpa_pkg::DS_STAT) begin
            stat_sel_reg <= ~stat_sel_reg; // [R22]
          end
        end else begin
          miso_reg <= out_sh_reg[6];
          out_sh_reg <= {out_sh_reg[5:0], 1'b0};
        end
      end
    end
  end
  assign link.miso_o = miso_reg;
  assign link.miso_oe = cs_active & streaming; // [R20]
  assign o_busy = busy_reg;
  assign o_write_permit = wpl_reg;
  assign o_user_used = used_reg;
endmodule : otpa_device

// ### otpa_host.sv
// Host controller end: frames one command per request on the link.
// Assumes the device samples on rising and shifts on falling sclk.
`timescale 1ns/1ns
module otpa_host (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Serial link
  otpa_if.host link,
  // Command request
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic [7:0] i_cmd_opcode,
  input wire logic i_cmd_addr_en,
  input wire logic [23:0] i_cmd_addr,
  input wire logic [1:0] i_cmd_dummy,
  input wire logic [8:0] i_cmd_len,
  input wire logic i_cmd_write,
  // Write data
  input wire logic [7:0] i_wdata,
  output logic o_wdata_take,
  // Read data and completion
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  output logic o_done
);

  otpa_pkg::otpa_host_state_t st_reg;
  logic [7:0] tmr_reg;
  logic [2:0] bit_reg;
  logic [9:0] pos_reg, total_reg, dstart_reg;
  logic [23:0] addr_reg;
  logic addr_en_reg, write_reg;
  logic [7:0] tx_sh_reg, rx_sh_reg;
  logic cs_n_reg, sclk_reg;
  logic [2:0] ms_reg;
  logic miso_flt_reg;

  // ==========================================================
  // Data-out synchroniser
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ms_reg <= {3{otpa_pkg::MISO_IDLE}};
      miso_flt_reg <= otpa_pkg::MISO_IDLE;
    end else if (i_ce) begin
      ms_reg <= {ms_reg[1:0], link.miso};
      if (ms_reg[1] == ms_reg[2]) begin
        miso_flt_reg <= ms_reg[2];
      end
    end
  end

  // ==========================================================
  // Byte selection
  function automatic logic [7:0] addr_byte(input logic [1:0] idx,
                                           input logic [23:0] a);
    unique case (idx)
      2'h1: addr_byte = a[23:16];
      2'h2: addr_byte = a[15:8];
      default: addr_byte = a[7:0];
    endcase
  endfunction : addr_byte

  wire half_end = (tmr_reg == 8'(otpa_pkg::SCLK_HALF_CYC - 1));
  wire [9:0] pos_nxt = pos_reg + 10'h001;
  wire [9:0] n_addr = i_cmd_addr_en ? 10'(otpa_pkg::ADDR_BYTES) : 10'h000;
  wire [9:0] n_addr_q = addr_en_reg ? 10'(otpa_pkg::ADDR_BYTES) : 10'h000;
  wire in_data_nxt = (pos_nxt >= dstart_reg);
  wire in_data = (pos_reg >= dstart_reg);
  wire [7:0] next_tx = (pos_nxt <= n_addr_q) ?
                       addr_byte(pos_nxt[1:0], addr_reg) :
                       (in_data_nxt && write_reg) ? i_wdata : 8'h00;

  // ==========================================================
  // Frame sequencer
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st_reg <= otpa_pkg::HS_IDLE;
      tmr_reg <= 8'h00;
      bit_reg <= 3'h0;
      pos_reg <= 10'h000;
      total_reg <= 10'h000;
      dstart_reg <= 10'h000;
      addr_reg <= 24'h000000;
      addr_en_reg <= 1'b0;
      write_reg <= 1'b0;
      tx_sh_reg <= 8'h00;
      rx_sh_reg <= 8'h00;
      cs_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
      o_rdata <= 8'h00;
      o_rdata_valid <= 1'b0;
      o_wdata_take <= 1'b0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_rdata_valid <= 1'b0;
      o_wdata_take <= 1'b0;
      o_done <= 1'b0;
      tmr_reg <= half_end ? 8'h00 : tmr_reg + 8'h01;
      unique case (st_reg)
        otpa_pkg::HS_IDLE: begin
          tmr_reg <= 8'h00;
          if (i_cmd_valid) begin
            addr_reg <= i_cmd_addr;
            addr_en_reg <= i_cmd_addr_en;
            write_reg <= i_cmd_write;
            dstart_reg <= 10'h001 + n_addr + 10'(i_cmd_dummy);
            total_reg <= 10'h001 + n_addr + 10'(i_cmd_dummy) +
                         10'(i_cmd_len);
            tx_sh_reg <= i_cmd_opcode; // [R05] [R18] [R21] [R22]
            pos_reg <= 10'h000;
            bit_reg <= 3'h0;
            cs_n_reg <= 1'b0;
            st_reg <= otpa_pkg::HS_LOW;
          end
        end
        otpa_pkg::HS_LOW: begin
          if (half_end) begin
            sclk_reg <= 1'b1;
            rx_sh_reg <= {rx_sh_reg[6:0], miso_flt_reg};
            st_reg <= otpa_pkg::HS_HIGH;
          end
        end
        otpa_pkg::HS_HIGH: begin
          if (half_end) begin
            sclk_reg <= 1'b0;
            bit_reg <= bit_reg + 3'h1;
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            st_reg <= otpa_pkg::HS_LOW;
            if (bit_reg == 3'h7) begin
              if (in_data && !write_reg) begin
                o_rdata <= rx_sh_reg;
                o_rdata_valid <= 1'b1;
              end
              if (pos_nxt == total_reg) begin
                st_reg <= otpa_pkg::HS_HOLD; // [R11]
              end else begin
                pos_reg <= pos_nxt;
                tx_sh_reg <= next_tx;
                o_wdata_take <= in_data_nxt & write_reg;
              end
            end
          end
        end
        otpa_pkg::HS_HOLD: begin
          if (half_end) begin
            cs_n_reg <= 1'b1; // [R11]
            st_reg <= otpa_pkg::HS_GAP;
          end
        end
        otpa_pkg::HS_GAP: begin
          if (half_end) begin
            o_done <= 1'b1;
            st_reg <= otpa_pkg::HS_IDLE;
          end
        end
      endcase
    end
  end

  assign o_cmd_ready = (st_reg == otpa_pkg::HS_IDLE);
  assign link.cs_n = cs_n_reg;
  assign link.sclk = sclk_reg;
  assign link.mosi = tx_sh_reg[7];

endmodule : otpa_host

// ### otpa_assertions.sv
// Checker for the serial link between host and region device.
// Assumes it sits beside the interface and sees the device status pins.
`timescale 1ns/1ns
module otpa_assertions #(
  parameter int PROG_CYCLES = otpa_pkg::PROG_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso,
  // Device status
  input wire logic o_busy,
  input wire logic o_write_permit,
  input wire logic o_user_used
);
  // ==========================================================
  // Busy length counter
  logic [15:0] busy_cnt_reg;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || !o_busy) begin
      busy_cnt_reg <= 16'h0000;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 16'h0001;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  sequence prog_start_s;
    $rose(o_busy);
  endsequence
  sequence frame_end_s;
    $rose(cs_n);
  endsequence

  prog_needs_latch_a: assert property (
    prog_start_s |-> $past(o_write_permit))
    else $error("program started without permit latch");
  latch_cleared_a: assert property (
    prog_start_s |-> !o_write_permit && o_user_used)
    else $error("latch or used flag wrong at program start");
  prog_at_release_a: assert property (
    prog_start_s |-> cs_n && $past(cs_n, 2))
    else $error("program started inside a frame");
  prog_once_a: assert property (
    prog_start_s |-> !$past(o_user_used))
    else $error("user half programmed twice");
  self_timed_a: assert property (
    $fell(o_busy) |-> int'(busy_cnt_reg) >= PROG_CYCLES - 1 &&
      int'(busy_cnt_reg) <= PROG_CYCLES + 1)
    else $error("busy length differs from program time");
  latch_set_a: assert property (
    $rose(o_write_permit) |-> $past(cs_n, 2))
    else $error("permit latch set inside a frame");
  latch_drop_a: assert property (
    $fell(o_write_permit) |-> $past(cs_n, 2))
    else $error("permit latch cleared inside a frame");
  out_float_a: assert property (
    frame_end_s |-> ##[1:6] !miso_oe)
    else $error("data out still driven after release");
  out_stays_off_a: assert property (
    cs_n [*7] |-> !miso_oe)
    else $error("data out driven while deselected");
  pull_up_a: assert property (
    !miso_oe |-> miso)
    else $error("released data line not high");
  drive_in_frame_a: assert property (
    $rose(miso_oe) |-> !cs_n && !$past(cs_n, 8))
    else $error("data out driven before command bits");
  sclk_idle_a: assert property (
    cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  sclk_half_a: assert property (
    $rose(sclk) |-> sclk [*8])
    else $error("serial clock high phase too short");
  mosi_idle_a: assert property (
    cs_n |-> !mosi)
    else $error("host data line high while deselected");
endmodule : otpa_assertions

// ### testbench.sv
// Self-checking bench: host and device joined by one link.
// Assumes the bench drives the host command side only.
`timescale 1ns/1ns
module testbench;
  localparam int PROG_N = 1000;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_cmd_valid = 1'b0;
  logic [7:0] i_cmd_opcode = 8'h00;
  logic i_cmd_addr_en = 1'b0;
  logic [23:0] i_cmd_addr = 24'h000000;
  logic [1:0] i_cmd_dummy = 2'h0;
  logic [8:0] i_cmd_len = 9'h000;
  logic i_cmd_write = 1'b0;
  logic [7:0] i_wdata = 8'h00;
  logic o_cmd_ready, o_wdata_take, o_rdata_valid, o_done;
  logic [7:0] o_rdata;
  logic o_busy, o_write_permit, o_user_used;
  logic [7:0] wbuf [0:127];
  logic [7:0] exp_mem [0:127];
  logic [7:0] rq [$];
  int wi = 0;
  int bad_count = 0;
  int checked = 0;

  always #50 i_mclk = ~i_mclk;

  otpa_if link ();
  otpa_host u_otpa_host (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_ce(1'b1), .link(link), .i_cmd_valid(i_cmd_valid),
    .o_cmd_ready(o_cmd_ready), .i_cmd_opcode(i_cmd_opcode),
    .i_cmd_addr_en(i_cmd_addr_en), .i_cmd_addr(i_cmd_addr),
    .i_cmd_dummy(i_cmd_dummy), .i_cmd_len(i_cmd_len),
    .i_cmd_write(i_cmd_write), .i_wdata(i_wdata),
    .o_wdata_take(o_wdata_take), .o_rdata(o_rdata),
    .o_rdata_valid(o_rdata_valid), .o_done(o_done));
  otpa_device #(.PROG_CYCLES(PROG_N)) u_otpa_device (.i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst), .i_ce(1'b1), .link(link), .o_busy(o_busy),
    .o_write_permit(o_write_permit), .o_user_used(o_user_used));
  otpa_assertions #(.PROG_CYCLES(PROG_N)) u_otpa_assertions (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .cs_n(link.cs_n),
    .sclk(link.sclk), .mosi(link.mosi), .miso_o(link.miso_o),
    .miso_oe(link.miso_oe), .miso(link.miso), .o_busy(o_busy),
    .o_write_permit(o_write_permit), .o_user_used(o_user_used));

  // ==========================================================
  // Write data feed and read data capture
  always @(posedge i_mclk) begin
    if (o_wdata_take) begin
      wi <= wi + 1;
      i_wdata <= wbuf[wi + 1];
    end
    if (o_rdata_valid) begin
      rq.push_back(o_rdata);
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic stop_test();
    $display("Counts: %0d checked, %0d bad", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk8(input string nm, input logic [7:0] e,
      input logic [7:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic do_reset();
    i_sys_rst <= 1'b1;
    repeat (8) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    for (int i = 0; i < 128; i++) begin
      exp_mem[i] = (i < otpa_pkg::USER_BYTES) ? otpa_pkg::ERASED_BYTE :
        otpa_pkg::SERIAL_SEED ^ 8'(i - otpa_pkg::USER_BYTES);
    end
  endtask : do_reset

  task automatic run_cmd(input logic [7:0] op, input logic aen,
      input logic [23:0] a, input logic [1:0] dm, input logic [8:0] n,
      input logic wr);
    int t;
    @(posedge i_mclk);
    wi <= 0;
    i_wdata <= wbuf[0];
    rq.delete();
    i_cmd_opcode <= op;
    i_cmd_addr_en <= aen;
    i_cmd_addr <= a;
    i_cmd_dummy <= dm;
    i_cmd_len <= n;
    i_cmd_write <= wr;
    i_cmd_valid <= 1'b1;
    @(posedge i_mclk);
    i_cmd_valid <= 1'b0;
    t = 0;
    while (o_done !== 1'b1 && t < 40000) begin
      @(posedge i_mclk);
      t++;
    end
    if (t >= 40000) begin
      bad_count++;
      $display("wrong value done: expected 1 seen 0");
      stop_test();
    end
    chk8("host ready", 8'h01, {7'h00, o_cmd_ready});
  endtask : run_cmd

  task automatic wren();
    run_cmd(otpa_pkg::OPC_WRITE_PERMIT, 1'b0, 24'h000000, 2'h0, 9'h000,
      1'b0);
  endtask : wren

  task automatic rd_status(output logic [7:0] s1, output logic [7:0] s2);
    run_cmd(otpa_pkg::OPC_STATUS, 1'b0, 24'h000000, 2'h0, 9'h002, 1'b0);
    s1 = rq[0];
    s2 = rq[1];
  endtask : rd_status

  task automatic prog(input logic [23:0] a, input int n,
      input logic [7:0] b);
    for (int i = 0; i < 128; i++) begin
      wbuf[i] = b + 8'(i);
    end
    run_cmd(otpa_pkg::OPC_REGION_PROG, 1'b1, a, 2'h0, 9'(n), 1'b1);
  endtask : prog

  task automatic rd_chk(input logic [6:0] a, input int n);
    run_cmd(otpa_pkg::OPC_REGION_READ, 1'b1, {17'h00000, a},
      2'(otpa_pkg::READ_DUMMY), 9'(n), 1'b0);
    for (int i = 0; i < n; i++) begin
      chk8("region byte", exp_mem[(int'(a) + i) % 128], rq[i]);
    end
  endtask : rd_chk

  // ==========================================================
  // Scenarios
  task automatic t_idle();
    logic [7:0] s1, s2;
    rd_status(s1, s2);
    chk8("status byte 1", 8'h00, s1);
    chk8("status byte 2", otpa_pkg::STAT_BYTE2, s2);
    prog(24'h000000, 4, 8'h20);
    chk8("busy without latch", 8'h00, {7'h00, o_busy});
    wren();
    rd_status(s1, s2);
    chk8("status after permit", 8'h02, s1);
    chk8("status byte 2 after permit", otpa_pkg::STAT_BYTE2, s2);
  endtask : t_idle

  task automatic t_abort();
    run_cmd(otpa_pkg::OPC_REGION_PROG, 1'b0, 24'h000000, 2'h0, 9'h000,
      1'b1);
    chk8("latch after short frame", 8'h00, {7'h00, o_write_permit});
    wren();
    prog(24'h000010, 0, 8'h30);
    chk8("latch after no data", 8'h00, {7'h00, o_write_permit});
    chk8("used after abort", 8'h00, {7'h00, o_user_used});
  endtask : t_abort

  task automatic t_wrap();
    logic [7:0] s1, s2;
    int t;
    wren();
    prog(24'hFFFF7E, 3, 8'hA0);
    chk8("busy after program", 8'h01, {7'h00, o_busy});
    rd_status(s1, s2);
    chk8("status while busy", 8'h01, s1);
    t = 0;
    while (s1[0] !== 1'b0 && t < 8) begin
      rd_status(s1, s2);
      t++;
    end
    chk8("status after program", 8'h00, s1);
    exp_mem[62] = 8'hA0;
    exp_mem[63] = 8'hA1;
    exp_mem[0] = 8'hA2;
    rd_chk(7'h00, 64);
    chk8("user half used", 8'h01, {7'h00, o_user_used});
    wren();
    prog(24'h000000, 2, 8'h55);
    chk8("busy on reprogram", 8'h00, {7'h00, o_busy});
    chk8("latch after refusal", 8'h00, {7'h00, o_write_permit});
    rd_chk(7'h00, 2);
  endtask : t_wrap

  task automatic t_last64();
    int t;
    do_reset();
    wren();
    prog(24'h000005, 70, 8'h10);
    run_cmd(otpa_pkg::OPC_REGION_READ, 1'b1, 24'h000040, 2'h2, 9'h001,
      1'b0);
    chk8("read while busy", 8'hFF, rq[0]);
    t = 0;
    while (o_busy !== 1'b0 && t < 2000) begin
      @(posedge i_mclk);
      t++;
    end
    chk8("busy cleared", 8'h00, {7'h00, o_busy});
    for (int n = 0; n < 70; n++) begin
      exp_mem[(5 + n) % 64] = 8'h10 + 8'(n);
    end
    rd_chk(7'h7E, 130);
  endtask : t_last64

  initial begin
    do_reset();
    t_idle();
    t_abort();
    t_wrap();
    t_last64();
    stop_test();
  end
endmodule : testbench
